// *** lvd_pkg.sv ***
// Package holding register addresses, field positions, reset values and timing for the detector.
package lvd_pkg;

   localparam logic [15:0] ADDR_PIN_DIR = 16'hff2c;
   localparam logic [15:0] ADDR_LEVEL_SEL = 16'hffbf;
   localparam logic [15:0] ADDR_DETECT_CTRL = 16'hffbe;

   localparam int BIT_ENABLE = 7;
   localparam int BIT_SOURCE = 2;
   localparam int BIT_ACTION = 1;
   localparam int BIT_FLAG = 0;
   localparam int BIT_SENSE_DIR = 0;

   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_DEFAULT_START = 8'h82;
   localparam logic [3:0] LEVEL_RESET = 4'h0;
   localparam logic [3:0] LEVEL_DEFAULT_START = 4'hf;
   localparam logic [7:0] PIN_DIR_RESET = 8'hff;
   localparam logic [6:0] PIN_DIR_UPPER = 7'h7f;

   localparam int CLK_MHZ = 200;
   localparam int STABLE_US = 10;
   localparam int FILTER_US = 200;
   localparam int STABLE_CYCLES = STABLE_US * CLK_MHZ;
   localparam int FILTER_CYCLES = FILTER_US * CLK_MHZ;
   localparam int CNT_W = 16;

   typedef struct packed {
      logic enable;
      logic source;
      logic action;
   } ctrl_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic bit_op;
      logic [2:0] bit_sel;
      logic [15:0] addr;
      logic [7:0] wdata;
   } cpu_req_type;

   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_STABILIZE = 2'b01,
      ST_RUN = 2'b11
   } det_state_type;

endpackage

// *** lvd_sync.sv ***
// Two flip-flop synchroniser for the comparator output.
`timescale 1ns/1ps
module lvd_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic d,
   output logic q
);

   logic meta_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule // lvd_sync

// *** lvd_timer.sv ***
// Down counter that reports done once a loaded count has elapsed.
`timescale 1ns/1ps
module lvd_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [lvd_pkg::CNT_W-1:0] count,
   input wire logic run,
   output logic done
);

   logic [lvd_pkg::CNT_W-1:0] cnt_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else if (load) begin
         cnt_reg <= count;
      end else if (run && cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   assign done = run && !load && (cnt_reg == '0);

endmodule // lvd_timer

// *** low_voltage_detect_ctrl.sv ***
// Low-voltage detector control: registers, comparator conditioning, reset and interrupt.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

// Summary of operation
// - Enable bit 7 starts comparator; clearing it stops detection and zeroes flag.
// - Source bit 2 picks supply versus external sense pin.
// - Action bit 0 gives interrupt on both falling and rising crossings.
// - Action bit 1 holds internal reset while input below threshold.
// - Flag bit 0 read-only, 1 while input below, 0 otherwise or disabled.
// - Non-detector reset loads control 82H or 00H; detector reset keeps it.
// - Flag sets only after 200 us below, counted after stabilisation.
// - Disabling in interrupt mode while below may raise the interrupt.
// - Level register holds 4-bit code choosing one of 16 supply thresholds.
// - Level register 00H on other reset, kept on own reset, 0FH on default start at power-on.
// - Sense pin selected uses fixed reference; level code ignored.
// - Direction bit 0 selects input at 1; register resets to FFH.
// - Setting action bit while input above gives no reset.
// - Detector reset and later non-detector resets set the interrupt mask flag; power-on does not.
// - Detector reset sets reset-cause flag bit 0.
module low_voltage_detect_ctrl (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic OTHER_RESET_N,
   input wire logic DEFAULT_DETECT_START,
   input wire logic POWER_ON,
   input wire logic CPU_WR,
   input wire logic CPU_RD,
   input wire logic CPU_BIT_OP,
   input wire logic [2:0] CPU_BIT_SEL,
   input wire logic [15:0] CPU_ADDR,
   input wire logic [7:0] CPU_WDATA,
   input wire logic COMP_BELOW,
   output logic [7:0] CPU_RDATA,
   output logic COMP_ENABLE,
   output logic COMP_SOURCE_SEL,
   output logic [3:0] SUPPLY_THRESHOLD,
   output logic SENSE_PIN_INPUT_SELECT,
   output logic LOW_VOLTAGE_IRQ,
   output logic INTERNAL_RESET,
   output logic LV_RESET_CAUSE_SET,
   output logic LV_IRQ_MASK_SET
);

   ////////////////////////////////////////////////////////////////////////////////

   lvd_pkg::cpu_req_type req;
   lvd_pkg::ctrl_type ctrl_reg;
   lvd_pkg::ctrl_type ctrl_next;
   lvd_pkg::det_state_type state_reg;
   lvd_pkg::det_state_type state_next;
   logic [3:0] level_reg;
   logic [3:0] level_next;
   logic sense_dir_reg;
   logic flag_reg;
   logic below_sync;
   logic below_prev_reg;
   logic stab_load;
   logic stab_done;
   logic filt_load;
   logic filt_done;
   logic wr_ctrl;
   logic wr_level;
   logic wr_dir;
   logic [7:0] ctrl_view;
   logic [7:0] level_view;
   logic [7:0] dir_view;
   logic [7:0] ctrl_wval;
   logic [7:0] level_wval;
   logic [7:0] dir_wval;
   logic reset_now;
   logic own_reset_reg;
   logic first_reset_reg;
   logic power_up_reg;

   assign req = '{wr: CPU_WR, rd: CPU_RD, bit_op: CPU_BIT_OP, bit_sel: CPU_BIT_SEL,
                  addr: CPU_ADDR, wdata: CPU_WDATA};

   ////////////////////////////////////////////////////////////////////////////////

   // The comparator is asynchronous; only the second synchroniser stage is used below.
   // two-stage synchroniser
   lvd_sync u_sync (
      .clk(MCLK),
      .rst_n(RESETN),
      .d(COMP_BELOW),
      .q(below_sync)
   );

   lvd_timer u_stab (
      .clk(MCLK),
      .rst_n(RESETN),
      .load(stab_load),
      .count(lvd_pkg::CNT_W'(lvd_pkg::STABLE_CYCLES - 1)),
      .run(state_reg == lvd_pkg::ST_STABILIZE),
      .done(stab_done)
   );

   lvd_timer u_filt (
      .clk(MCLK),
      .rst_n(RESETN),
      .load(filt_load),
      .count(lvd_pkg::CNT_W'(lvd_pkg::FILTER_CYCLES - 1)),
      .run(state_reg == lvd_pkg::ST_RUN && below_sync),
      .done(filt_done)
   );

   ////////////////////////////////////////////////////////////////////////////////

   assign wr_ctrl = req.wr && req.addr == lvd_pkg::ADDR_DETECT_CTRL;
   assign wr_level = req.wr && req.addr == lvd_pkg::ADDR_LEVEL_SEL;
   assign wr_dir = req.wr && req.addr == lvd_pkg::ADDR_PIN_DIR;

   assign ctrl_view = {ctrl_reg.enable, 4'h0, ctrl_reg.source, ctrl_reg.action, flag_reg};
   assign level_view = {4'h0, level_reg};
   assign dir_view = {lvd_pkg::PIN_DIR_UPPER, sense_dir_reg};

   // Bit instructions modify one bit of the current value; byte writes replace it.
   function automatic logic [7:0] merge(input logic [7:0] cur, input logic cpu_bit_op,
                                        input logic [2:0] sel, input logic [7:0] wd);
      logic [7:0] v;
      v = cur;
      if (cpu_bit_op) begin
         v[sel] = wd[0];
      end else begin
         v = wd;
      end
      return v;
   endfunction

   assign ctrl_wval = merge(ctrl_view, req.bit_op, req.bit_sel, req.wdata);
   assign level_wval = merge(level_view, req.bit_op, req.bit_sel, req.wdata);
   assign dir_wval = merge(dir_view, req.bit_op, req.bit_sel, req.wdata);

   // Only the writable control bits are taken; the flag and unused bits stay as they are.
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next.enable = ctrl_wval[lvd_pkg::BIT_ENABLE];
         ctrl_next.source = ctrl_wval[lvd_pkg::BIT_SOURCE];
         ctrl_next.action = ctrl_wval[lvd_pkg::BIT_ACTION];
      end
   end

   always_comb begin
      level_next = level_reg;
      if (wr_level) begin
         level_next = level_wval[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////

   // Power-on counts as a non-detector reset, so its defaults load one edge after release.
   // A control or level register write on that first edge is lost; a direction write is still taken.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         power_up_reg <= 1'b1;
      end else begin
         power_up_reg <= 1'b0;
      end
   end

   // control reset source handling; level register reset handling
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_reg <= '0;
         level_reg <= lvd_pkg::LEVEL_RESET;
         first_reset_reg <= 1'b1;
      end else if (!OTHER_RESET_N || power_up_reg) begin
         first_reset_reg <= 1'b1;
         if (DEFAULT_DETECT_START) begin
            ctrl_reg.enable <= lvd_pkg::CTRL_DEFAULT_START[lvd_pkg::BIT_ENABLE];
            ctrl_reg.source <= lvd_pkg::CTRL_DEFAULT_START[lvd_pkg::BIT_SOURCE];
            ctrl_reg.action <= lvd_pkg::CTRL_DEFAULT_START[lvd_pkg::BIT_ACTION];
         end else begin
            ctrl_reg <= '0;
         end
         if (DEFAULT_DETECT_START && (POWER_ON || power_up_reg)) begin
            level_reg <= lvd_pkg::LEVEL_DEFAULT_START;
         end else begin
            level_reg <= lvd_pkg::LEVEL_RESET;
         end
      end else begin
         first_reset_reg <= 1'b0;
         ctrl_reg <= ctrl_next;
         level_reg <= level_next;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         sense_dir_reg <= lvd_pkg::PIN_DIR_RESET[lvd_pkg::BIT_SENSE_DIR];
      end else if (!OTHER_RESET_N) begin
         sense_dir_reg <= lvd_pkg::PIN_DIR_RESET[lvd_pkg::BIT_SENSE_DIR];
      end else if (wr_dir) begin
         sense_dir_reg <= dir_wval[lvd_pkg::BIT_SENSE_DIR];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      state_next = state_reg;
      stab_load = 1'b0;
      unique case (state_reg)
         lvd_pkg::ST_OFF: begin
            if (ctrl_reg.enable) begin
               state_next = lvd_pkg::ST_STABILIZE;
               stab_load = 1'b1;
            end
         end
         lvd_pkg::ST_STABILIZE: begin
            if (!ctrl_reg.enable) begin
               state_next = lvd_pkg::ST_OFF;
            end else if (stab_done) begin
               state_next = lvd_pkg::ST_RUN;
            end
         end
         lvd_pkg::ST_RUN: begin
            if (!ctrl_reg.enable) begin
               state_next = lvd_pkg::ST_OFF;
            end
         end
         default: begin
            state_next = lvd_pkg::ST_OFF;
         end
      endcase
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= lvd_pkg::ST_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // Any cycle above the threshold restarts the full filter time.
   // filter restarts whenever input is not below
   assign filt_load = state_reg != lvd_pkg::ST_RUN || !below_sync;

   // flag follows filtered level; zero when disabled
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         flag_reg <= 1'b0;
      end else if (!ctrl_reg.enable || state_reg != lvd_pkg::ST_RUN) begin
         flag_reg <= 1'b0;
      end else if (filt_done) begin
         flag_reg <= 1'b1;
      end else if (!below_sync) begin
         flag_reg <= 1'b0;
      end
   end

   // Previous flag value, so that both crossings of the threshold can be seen.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         below_prev_reg <= 1'b0;
      end else begin
         below_prev_reg <= flag_reg;
      end
   end

   // reset while below; no reset when above at action set
   assign reset_now = ctrl_reg.action && flag_reg;

   ////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         LOW_VOLTAGE_IRQ <= 1'b0;
      end else begin
         // both crossings; flag drop on disable also signals
         LOW_VOLTAGE_IRQ <= !ctrl_reg.action && (flag_reg != below_prev_reg);
      end
   end

   // The detector's own reset leaves every register here untouched; it only leaves by this pin.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         INTERNAL_RESET <= 1'b0;
         own_reset_reg <= 1'b0;
      end else begin
         INTERNAL_RESET <= reset_now;
         own_reset_reg <= reset_now;
      end
   end

   // Both pulses mark only the first cycle of a reset, so a long reset counts once.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         LV_RESET_CAUSE_SET <= 1'b0;
         LV_IRQ_MASK_SET <= 1'b0;
      end else begin
         LV_RESET_CAUSE_SET <= reset_now && !own_reset_reg;
         LV_IRQ_MASK_SET <= (reset_now && !own_reset_reg) || (!OTHER_RESET_N && !first_reset_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         COMP_ENABLE <= 1'b0;
         COMP_SOURCE_SEL <= 1'b0;
         SUPPLY_THRESHOLD <= lvd_pkg::LEVEL_RESET;
         SENSE_PIN_INPUT_SELECT <= 1'b1;
      end else begin
         COMP_ENABLE <= ctrl_reg.enable;
         COMP_SOURCE_SEL <= ctrl_reg.source;
         // level code; ignored for sense pin
         SUPPLY_THRESHOLD <= ctrl_reg.source ? lvd_pkg::LEVEL_RESET : level_reg;
         SENSE_PIN_INPUT_SELECT <= sense_dir_reg;
      end
   end

   // Read data is registered and holds until the next read; unmapped addresses give zero.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         CPU_RDATA <= 8'h00;
      end else if (req.rd) begin
         unique case (req.addr)
            lvd_pkg::ADDR_DETECT_CTRL: CPU_RDATA <= ctrl_view;
            lvd_pkg::ADDR_LEVEL_SEL: CPU_RDATA <= level_view;
            lvd_pkg::ADDR_PIN_DIR: CPU_RDATA <= dir_view;
            default: CPU_RDATA <= 8'h00;
         endcase
      end
   end

endmodule // low_voltage_detect_ctrl

// *** lvd_comparator.sv ***
// Behavioural comparator standing beside the detector.
`timescale 1ns/1ps
module lvd_comparator (
   input wire logic clk,
   input wire logic enable,
   input wire logic source,
   input wire logic sense_input,
   input wire logic [3:0] level,
   input wire logic [4:0] supply_step,
   input wire logic ext_below,
   output logic below
);
   // A stopped comparator or a pin left as output gives no usable level.
   logic noise_reg = 1'b0;
   always @(posedge clk) begin
      noise_reg <= !noise_reg;
   end
   always_comb begin
      if (!enable) begin
         below = noise_reg;
      end else if (source) begin
         below = sense_input ? ext_below : noise_reg;
      end else begin
         below = supply_step > {1'b0, level};
      end
   end
endmodule // lvd_comparator

// *** low_voltage_detect_ctrl_checker.sv ***
// Port checker of the low-voltage detector control block.
`timescale 1ns/1ps
module low_voltage_detect_ctrl_checker (
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic OTHER_RESET_N,
   input wire logic DEFAULT_DETECT_START,
   input wire logic POWER_ON,
   input wire logic CPU_WR,
   input wire logic CPU_BIT_OP,
   input wire logic [15:0] CPU_ADDR,
   input wire logic [7:0] CPU_WDATA,
   input wire logic COMP_BELOW,
   input wire logic COMP_ENABLE,
   input wire logic COMP_SOURCE_SEL,
   input wire logic [3:0] SUPPLY_THRESHOLD,
   input wire logic SENSE_PIN_INPUT_SELECT,
   input wire logic LOW_VOLTAGE_IRQ,
   input wire logic INTERNAL_RESET,
   input wire logic LV_RESET_CAUSE_SET,
   input wire logic LV_IRQ_MASK_SET
);
   default clocking @(posedge MCLK);
   endclocking
   default disable iff (!RESETN);
   logic [15:0] below_cnt;
   logic ctrl_wr;
   assign ctrl_wr = CPU_WR && !CPU_BIT_OP && OTHER_RESET_N
      && CPU_ADDR == lvd_pkg::ADDR_DETECT_CTRL;
   // Counts how long the comparator has reported below.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         below_cnt <= 16'h0000;
      end else if (!COMP_BELOW) begin
         below_cnt <= 16'h0000;
      end else if (below_cnt != 16'hffff) begin
         below_cnt <= below_cnt + 16'h0001;
      end
   end
   sequence reset_entry;
      $rose(INTERNAL_RESET);
   endsequence
   sequence above_settled;
      !COMP_BELOW [*6];
   endsequence
   enable_write_a: assert property (ctrl_wr && CPU_WDATA[7] |-> ##[1:2] COMP_ENABLE)
      else $error("enable not set by write");
   source_write_a: assert property (ctrl_wr && CPU_WDATA[2] |-> ##[1:2] COMP_SOURCE_SEL)
      else $error("source not set by write");
   fixed_ref_a: assert property (COMP_SOURCE_SEL && $past(COMP_SOURCE_SEL) |->
      SUPPLY_THRESHOLD == 4'h0) else $error("level code used with sense pin");
   filter_time_a: assert property (reset_entry |-> below_cnt >= lvd_pkg::FILTER_CYCLES)
      else $error("reset before filter time");
   cause_flag_a: assert property (reset_entry |-> ##[0:1] LV_RESET_CAUSE_SET)
      else $error("no reset cause pulse");
   mask_on_cause_a: assert property (LV_RESET_CAUSE_SET |-> LV_IRQ_MASK_SET)
      else $error("mask not set on detector reset");
   mask_on_other_a: assert property (!OTHER_RESET_N |-> ##[0:2] LV_IRQ_MASK_SET)
      else $error("mask not set on other reset");
   reset_release_a: assert property (above_settled |-> !INTERNAL_RESET)
      else $error("reset held while above");
   irq_pulse_a: assert property (LOW_VOLTAGE_IRQ |=> !LOW_VOLTAGE_IRQ)
      else $error("interrupt longer than one cycle");
   other_reset_a: assert property (!OTHER_RESET_N |-> ##[1:2] (COMP_ENABLE ==
      DEFAULT_DETECT_START && !COMP_SOURCE_SEL && SENSE_PIN_INPUT_SELECT))
      else $error("wrong state after other reset");
   level_default_a: assert property (!OTHER_RESET_N && POWER_ON && DEFAULT_DETECT_START
      |-> ##[1:2] SUPPLY_THRESHOLD == 4'hf) else $error("level not 0f at power up");
endmodule // low_voltage_detect_ctrl_checker
bind low_voltage_detect_ctrl low_voltage_detect_ctrl_checker chk (
   .MCLK, .RESETN, .OTHER_RESET_N, .DEFAULT_DETECT_START, .POWER_ON,
   .CPU_WR, .CPU_BIT_OP, .CPU_ADDR, .CPU_WDATA, .COMP_BELOW, .COMP_ENABLE,
   .COMP_SOURCE_SEL, .SUPPLY_THRESHOLD, .SENSE_PIN_INPUT_SELECT, .LOW_VOLTAGE_IRQ,
   .INTERNAL_RESET, .LV_RESET_CAUSE_SET, .LV_IRQ_MASK_SET
);

// *** low_voltage_detect_ctrl_tb_top.sv ***
// Self-checking bench for the low-voltage detector control block.
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin failures++; \
   $display("unexpected %s expected %h seen %h", n, e, s); end end
module low_voltage_detect_ctrl_tb_top;
   localparam logic [15:0] a_ctl = lvd_pkg::ADDR_DETECT_CTRL;
   localparam logic [15:0] a_lvl = lvd_pkg::ADDR_LEVEL_SEL;
   localparam logic [15:0] a_dir = lvd_pkg::ADDR_PIN_DIR;
   localparam int filt = lvd_pkg::FILTER_CYCLES + 100;
   logic mclk, resetn, other_n, dflt, pwr, wr, rd, bop, below, ext_below;
   logic en, src, dir, irq, ires, cause, mask;
   logic [2:0] bsel;
   logic [3:0] thr;
   logic [4:0] supply;
   logic [7:0] wdata, rdata;
   logic [15:0] addr;
   int failures, check_count, irq_seen, ires_seen, cause_seen, mask_seen;
   low_voltage_detect_ctrl dut (
      .MCLK(mclk), .RESETN(resetn), .OTHER_RESET_N(other_n),
      .DEFAULT_DETECT_START(dflt), .POWER_ON(pwr), .CPU_WR(wr), .CPU_RD(rd),
      .CPU_BIT_OP(bop), .CPU_BIT_SEL(bsel), .CPU_ADDR(addr), .CPU_WDATA(wdata),
      .COMP_BELOW(below), .CPU_RDATA(rdata), .COMP_ENABLE(en), .COMP_SOURCE_SEL(src),
      .SUPPLY_THRESHOLD(thr), .SENSE_PIN_INPUT_SELECT(dir), .LOW_VOLTAGE_IRQ(irq),
      .INTERNAL_RESET(ires), .LV_RESET_CAUSE_SET(cause), .LV_IRQ_MASK_SET(mask)
   );
   lvd_comparator cmp (
      .clk(mclk), .enable(en), .source(src), .sense_input(dir), .level(thr),
      .supply_step(supply), .ext_below(ext_below), .below(below)
   );
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = !mclk;
   end
   always @(posedge mclk) begin
      if (irq === 1'b1) irq_seen++;
      if (ires === 1'b1) ires_seen++;
      if (cause === 1'b1) cause_seen++;
      if (mask === 1'b1) mask_seen++;
   end
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d, input logic b,
      input logic [2:0] s);
      addr = a;
      wdata = d;
      bop = b;
      bsel = s;
      wr = 1'b1;
      @(negedge mclk);
      wr = 1'b0;
      @(negedge mclk);
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      addr = a;
      rd = 1'b1;
      @(negedge mclk);
      rd = 1'b0;
      @(negedge mclk);
      `CHK("rdata", e, rdata)
   endtask
   task automatic await(ref int c, input int v, input int lim);
      int n;
      n = 0;
      while (c < v && n < lim) begin
         @(negedge mclk);
         n++;
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge mclk);
      failures++;
      tally_and_finish();
   end
   initial begin
      resetn = 1'b0;
      other_n = 1'b1;
      dflt = 1'b0;
      pwr = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      bop = 1'b0;
      bsel = 3'h0;
      addr = 16'h0000;
      wdata = 8'h00;
      ext_below = 1'b0;
      supply = 5'h03;
      repeat (16) @(negedge mclk);
      resetn = 1'b1;
      @(negedge mclk);
      rd_chk(a_ctl, 8'h00);
      rd_chk(a_lvl, 8'h00);
      rd_chk(a_dir, 8'hff);
      rd_chk(16'h0000, 8'h00);
      wr_reg(a_lvl, 8'h0f, 1'b0, 3'h0);
      rd_chk(a_lvl, 8'h0f);
      wr_reg(a_ctl, 8'hff, 1'b0, 3'h0);
      rd_chk(a_ctl, 8'h86);
      `CHK("threshold", 4'h0, thr)
      wr_reg(a_ctl, 8'h00, 1'b0, 3'h0);
      `CHK("threshold", 4'hf, thr)
      wr_reg(a_dir, 8'h00, 1'b0, 3'h0);
      rd_chk(a_dir, 8'hfe);
      `CHK("direction", 1'b0, dir)
      wr_reg(a_dir, 8'hff, 1'b0, 3'h0);
      wr_reg(a_lvl, 8'h05, 1'b0, 3'h0);
      wr_reg(a_ctl, 8'h80, 1'b0, 3'h0);
      repeat (lvd_pkg::STABLE_CYCLES + 10) @(negedge mclk);
      `CHK("irq count", 0, irq_seen)
      rd_chk(a_ctl, 8'h80);
      supply = 5'h09;
      await(irq_seen, 1, filt);
      `CHK("irq count", 1, irq_seen)
      rd_chk(a_ctl, 8'h81);
      supply = 5'h03;
      await(irq_seen, 2, 10);
      `CHK("irq count", 2, irq_seen)
      rd_chk(a_ctl, 8'h80);
      wr_reg(a_ctl, 8'h01, 1'b1, 3'h1);
      repeat (10) @(negedge mclk);
      `CHK("internal reset", 1'b0, ires)
      supply = 5'h09;
      await(ires_seen, 1, filt);
      `CHK("internal reset", 1'b1, ires)
      `CHK("cause count", 1, cause_seen)
      `CHK("mask count", 1, mask_seen)
      rd_chk(a_ctl, 8'h83);
      rd_chk(a_lvl, 8'h05);
      wr_reg(a_ctl, 8'h00, 1'b1, 3'h1);
      repeat (6) @(negedge mclk);
      `CHK("internal reset", 1'b0, ires)
      wr_reg(a_ctl, 8'h00, 1'b1, 3'h7);
      await(irq_seen, 3, 10);
      `CHK("irq count", 3, irq_seen)
      rd_chk(a_ctl, 8'h00);
      dflt = 1'b1;
      pwr = 1'b1;
      other_n = 1'b0;
      repeat (2) @(negedge mclk);
      other_n = 1'b1;
      @(negedge mclk);
      rd_chk(a_ctl, 8'h82);
      rd_chk(a_lvl, 8'h0f);
      `CHK("mask seen", 1'b1, mask_seen > 1)
      wr_reg(a_ctl, 8'h00, 1'b0, 3'h0);
      rd_chk(a_ctl, 8'h00);
      wr_reg(a_ctl, 8'h06, 1'b0, 3'h0);
      dflt = 1'b0;
      pwr = 1'b0;
      other_n = 1'b0;
      @(negedge mclk);
      other_n = 1'b1;
      @(negedge mclk);
      rd_chk(a_ctl, 8'h00);
      rd_chk(a_lvl, 8'h00);
      `CHK("mask seen", 1'b1, mask_seen > 2)
      tally_and_finish();
   end
endmodule // low_voltage_detect_ctrl_tb_top
